/* File: hw/dier_pkg.sv */
// Package with register map, field layouts and event codes of the I/O event reporter.
package dier_pkg;

  // Register byte offsets.
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_EDGE_EN = 12'h004;
  localparam logic [11:0] ADDR_CNT_EN = 12'h008;
  localparam logic [11:0] ADDR_EVENT = 12'h00c;
  localparam logic [11:0] ADDR_CHAN_MAP = 12'h010;
  localparam logic [11:0] ADDR_ACK = 12'h014;
  localparam logic [11:0] ADDR_DIAG = 12'h018;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h01c;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h020;
  localparam logic [11:0] ADDR_STATUS = 12'h024;

  // Reset values.
  localparam logic [31:0] EDGE_EN_RST = 32'h0000_0000;
  localparam logic [9:0] CNT_EN_RST = 10'h000;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // Fields of the control register.
  localparam int CTRL_COUNT_MODE = 0;

  // Interrupt status bit positions.
  localparam int IRQ_EVENT = 0;
  localparam int IRQ_LOST = 1;
  localparam int IRQ_LOAD = 2;
  localparam int IRQ_ABSEQ = 3;
  localparam int IRQ_BITS = 4;

  // Diagnostic error codes.
  localparam logic [15:0] DIAG_NONE = 16'h0000;
  localparam logic [15:0] DIAG_LOAD_MISSING = 16'h0011;
  localparam logic [15:0] DIAG_IRQ_LOST = 16'h0016;
  localparam logic [15:0] DIAG_AB_SEQ = 16'h0500;

  // Event information fields.
  localparam logic [15:0] INFO_STRUCT_ID = 16'h0001;
  localparam logic [7:0] EVT_RISE = 8'h01;
  localparam logic [7:0] EVT_FALL = 8'h02;
  localparam logic [7:0] CNT_CHAN = 8'h10;
  localparam int NUM_CH = 16;
  localparam int NUM_CNT_EVT = 10;

  // Fault indicator blink: half period 250 ms at 125 MHz.
  localparam int BLINK_HALF_MS = 250;
  localparam int CLK_KHZ = 125000;
  localparam int BLINK_HALF_CYC = BLINK_HALF_MS * CLK_KHZ;

  // Pending event record handed to the host.
  typedef struct packed {
    logic [15:0] struct_id;
    logic [7:0] channel;
    logic [7:0] event_code;
  } dier_event_s;

  // Counter event strobes, bit n is event type n+1.
  typedef struct packed {
    logic direction;
    logic sync;
    logic capture;
    logic zero;
    logic cmp1;
    logic cmp0;
    logic underflow;
    logic overflow;
    logic gate_close;
    logic gate_open;
  } dier_cnt_evt_s;

  typedef enum logic [0:0] {
    ST_IDLE,
    ST_PENDING
  } dier_state_e;

endpackage : dier_pkg

/* File: hw/dier_top.sv */
// Event reporter for the digital on-board I/O: edge and counter events, diagnostics, APB.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ns

// Summary of operation
// - Diagnostic event gives alarm and blinking fault
// - Missing load supply reports code 11h
// - Event during pending one dropped, code 16h
// - Bad encoder A/B sequence reports code 500h
// - Each input interrupts on rising, falling edge
// - Channel bit map word reports source channel, zero for counter events
// - Event info starts with identifier 0001h
// - Channel byte 00h to 0Fh follows, 10h for counter events
// - Gate open type 1, close type 2
// - Overflow type 3, underflow type 4
// - Compare output 0 type 5, 1 type 6
// - Non-pulse count change raises no compare
// - Zero crossing raises type 7
// - Capture raises type 8, counting mode only
// - Reference or input synchronization raises type 9
// - Direction change raises type 10
// - Direction resets 0, first step after reset silent
module dier_top
  import dier_pkg::*;
#(
  parameter int BLINK_HALF = BLINK_HALF_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [15:0] digital_in,
  input wire logic load_supply_ok,
  input wire dier_cnt_evt_s cnt_evt,
  input wire logic cnt_by_pulse,
  input wire logic cnt_dir_down,
  input wire logic cnt_step,
  input wire logic ab_seq_error,
  output logic irq,
  output logic hw_irq,
  output logic diag_alarm,
  output logic fault_indicator,
  output logic direction_status_bit
);

  // APB decode; every access completes in its first access cycle.
  logic wr_en;
  logic rd_en;
  assign wr_en = psel & penable & pwrite;
  assign rd_en = psel & penable & ~pwrite;
  assign pready = 1'b1;

  // Register state.
  logic [31:0] edge_en;
  logic [31:0] next_edge_en;
  logic [9:0] cnt_en;
  logic [9:0] next_cnt_en;
  logic count_mode;
  logic next_count_mode;
  logic [3:0] irq_mask;
  logic [3:0] next_irq_mask;
  logic [3:0] irq_stat;
  logic [3:0] next_irq_stat;
  logic [15:0] diag_code;
  logic [15:0] next_diag_code;
  logic [15:0] in_q;
  logic [15:0] next_in_q;
  logic load_q;
  logic next_load_q;
  logic ab_q;
  logic next_ab_q;
  logic dir_valid;
  logic next_dir_valid;
  logic next_dir;
  dier_state_e state;
  dier_state_e next_state;
  dier_event_s evt;
  dier_event_s next_evt;
  logic [15:0] chan_map;
  logic [15:0] next_chan_map;
  logic [31:0] blink_cnt;
  logic [31:0] next_blink_cnt;
  logic blink;
  logic next_blink;

  // Raw event requests.
  logic [15:0] rise_req;
  logic [15:0] fall_req;
  logic [9:0] cnt_req;
  logic edge_any;
  logic cnt_any;
  logic load_event;
  logic ab_event;
  logic lost_event;
  logic ack_wr;
  logic [7:0] pick_chan;
  logic [7:0] pick_code;

  // Per channel edge detection, each edge gated by its own enable bit.
  // Pins are taken as synchronous, so no stages are spent on them here; a pin fed
  // from another clock domain needs a synchroniser ahead of this block.
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_edge
      assign rise_req[g] = digital_in[g] & ~in_q[g] & edge_en[g];
      assign fall_req[g] = ~digital_in[g] & in_q[g] & edge_en[g + NUM_CH];
    end
  endgenerate

  // Counter events, filtered by enables and by the qualifications they need.
  always_comb begin
    cnt_req = cnt_evt & cnt_en;
    // Compare matches after a load or preset are not real count pulses.
    if (!cnt_by_pulse) begin
      cnt_req[4] = 1'b0;
      cnt_req[5] = 1'b0;
    end
    cnt_req[7] = cnt_req[7] & count_mode;
    // Reversal only counts against a direction already seen since reset.
    cnt_req[9] = cnt_step & dir_valid & (cnt_dir_down != direction_status_bit)
      & cnt_en[9];
  end

  assign edge_any = |{rise_req, fall_req};
  assign cnt_any = |cnt_req;
  assign load_event = ~load_supply_ok & load_q;
  assign ab_event = ab_seq_error & ~ab_q;
  assign ack_wr = wr_en & (paddr == ADDR_ACK) & pwdata[0];

  // Choose the lowest numbered source: edges first, then counter types.
  // Sources that lose in the same cycle are not counted as lost, because the host
  // only ever sees one record; this keeps the lost flag for real overruns.
  always_comb begin
    pick_chan = 8'h00;
    pick_code = 8'h00;
    for (int i = NUM_CNT_EVT - 1; i >= 0; i--) begin
      if (cnt_req[i]) begin
        pick_chan = CNT_CHAN;
        pick_code = 8'(i + 1);
      end
    end
    for (int i = NUM_CH - 1; i >= 0; i--) begin
      if (fall_req[i]) begin
        pick_chan = 8'(i);
        pick_code = EVT_FALL;
      end
      if (rise_req[i]) begin
        pick_chan = 8'(i);
        pick_code = EVT_RISE;
      end
    end
  end

  // Pending event handshake; a new event while one waits is lost.
  always_comb begin
    next_state = state;
    next_evt = evt;
    next_chan_map = chan_map;
    lost_event = 1'b0;
    unique case (state)
      ST_IDLE: begin
        if (edge_any || cnt_any) begin
          next_state = ST_PENDING;
          next_evt.struct_id = INFO_STRUCT_ID;
          next_evt.channel = pick_chan;
          next_evt.event_code = pick_code;
          next_chan_map = edge_any ? (16'h0001 << pick_chan[3:0]) : 16'h0000;
        end
      end
      ST_PENDING: begin
        lost_event = edge_any | cnt_any;
        if (ack_wr) begin
          next_state = ST_IDLE;
        end
      end
    endcase
  end

  // Level history of the inputs whose edges are events.
  always_comb begin
    next_in_q = digital_in;
    next_load_q = load_supply_ok;
    next_ab_q = ab_seq_error;
  end

  // Direction tracking; the first step after reset only records a direction.
  always_comb begin
    next_dir = direction_status_bit;
    next_dir_valid = dir_valid;
    if (cnt_step) begin
      next_dir = cnt_dir_down;
      next_dir_valid = 1'b1;
    end
  end

  // Software control registers; writes to read-only or unmapped words are ignored.
  always_comb begin
    next_edge_en = edge_en;
    next_cnt_en = cnt_en;
    next_count_mode = count_mode;
    next_irq_mask = irq_mask;
    if (wr_en) begin
      unique case (paddr)
        ADDR_CTRL: next_count_mode = pwdata[CTRL_COUNT_MODE];
        ADDR_EDGE_EN: next_edge_en = pwdata;
        ADDR_CNT_EN: next_cnt_en = pwdata[9:0];
        ADDR_IRQ_MASK: next_irq_mask = pwdata[3:0];
        default: ;
      endcase
    end
  end

  // Sticky status; hardware sets follow the software clear, so a same-cycle event wins.
  always_comb begin
    next_irq_stat = irq_stat;
    if (wr_en && paddr == ADDR_IRQ_STAT) begin
      next_irq_stat = irq_stat & ~pwdata[3:0];
    end
    if (next_state == ST_PENDING && state == ST_IDLE) begin
      next_irq_stat[IRQ_EVENT] = 1'b1;
    end
    if (lost_event) begin
      next_irq_stat[IRQ_LOST] = 1'b1;
    end
    if (ab_event) begin
      next_irq_stat[IRQ_ABSEQ] = 1'b1;
    end
    if (load_event) begin
      next_irq_stat[IRQ_LOAD] = 1'b1;
    end
  end

  // Diagnostic code; any write to the diagnostic word clears it. With several faults in one cycle the supply
  // loss is kept, as it is the likeliest cause of the others.
  always_comb begin
    next_diag_code = diag_code;
    if (wr_en && paddr == ADDR_DIAG) begin
      next_diag_code = DIAG_NONE;
    end
    if (lost_event) begin
      next_diag_code = DIAG_IRQ_LOST;
    end
    if (ab_event) begin
      next_diag_code = DIAG_AB_SEQ;
    end
    if (load_event) begin
      next_diag_code = DIAG_LOAD_MISSING;
    end
  end

  // Blink timer runs only while a diagnostic code is reported.
  always_comb begin
    next_blink_cnt = blink_cnt;
    next_blink = blink;
    if (diag_code == DIAG_NONE) begin
      next_blink_cnt = 32'h0000_0000;
      next_blink = 1'b0;
    end else if (blink_cnt >= 32'(BLINK_HALF - 1)) begin
      next_blink_cnt = 32'h0000_0000;
      next_blink = ~blink;
    end else begin
      next_blink_cnt = blink_cnt + 32'h0000_0001;
    end
  end

  // Pending event registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= ST_IDLE;
      evt <= '0;
      chan_map <= 16'h0000;
    end else begin
      state <= next_state;
      evt <= next_evt;
      chan_map <= next_chan_map;
    end
  end

  // Software control registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      edge_en <= EDGE_EN_RST;
      cnt_en <= CNT_EN_RST;
      count_mode <= 1'b0;
      irq_mask <= IRQ_MASK_RST;
    end else begin
      edge_en <= next_edge_en;
      cnt_en <= next_cnt_en;
      count_mode <= next_count_mode;
      irq_mask <= next_irq_mask;
    end
  end

  // Sticky status register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_stat <= 4'h0;
    end else begin
      irq_stat <= next_irq_stat;
    end
  end

  // Diagnostic code register.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      diag_code <= DIAG_NONE;
    end else begin
      diag_code <= next_diag_code;
    end
  end

  // Input history; the supply starts as present so that reset gives no false loss edge.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_q <= 16'h0000;
      load_q <= 1'b1;
      ab_q <= 1'b0;
    end else begin
      in_q <= next_in_q;
      load_q <= next_load_q;
      ab_q <= next_ab_q;
    end
  end

  // Direction status and whether any step has been seen since reset.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      direction_status_bit <= 1'b0;
      dir_valid <= 1'b0;
    end else begin
      direction_status_bit <= next_dir;
      dir_valid <= next_dir_valid;
    end
  end

  // Blink timer registers.
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_cnt <= 32'h0000_0000;
      blink <= 1'b0;
    end else begin
      blink_cnt <= next_blink_cnt;
      blink <= next_blink;
    end
  end

  // Read mux; unmapped addresses read zero and answer with an error.
  always_comb begin
    prdata = 32'h0000_0000;
    pslverr = 1'b0;
    unique case (paddr)
      ADDR_CTRL: prdata = {31'h0, count_mode};
      ADDR_EDGE_EN: prdata = edge_en;
      ADDR_CNT_EN: prdata = {22'h0, cnt_en};
      ADDR_EVENT: prdata = evt;
      ADDR_CHAN_MAP: prdata = {16'h0, chan_map};
      ADDR_ACK: prdata = {31'h0, state == ST_PENDING};
      ADDR_DIAG: prdata = {16'h0, diag_code};
      ADDR_IRQ_STAT: prdata = {28'h0, irq_stat};
      ADDR_IRQ_MASK: prdata = {28'h0, irq_mask};
      ADDR_STATUS: prdata = {29'h0, blink, load_supply_ok, direction_status_bit};
      default: pslverr = psel & penable;
    endcase
    if (!rd_en) begin
      prdata = 32'h0000_0000;
    end
  end

  // Interrupt and indicator outputs.
  assign irq = |(irq_stat & irq_mask);
  assign hw_irq = (state == ST_PENDING);
  assign diag_alarm = (diag_code != DIAG_NONE);
  assign fault_indicator = blink;

endmodule : dier_top

/* File: tb/dier_host.sv */
// Host model: APB master that reads events and acknowledges them.
`timescale 1ns/1ns
module dier_host
  import dier_pkg::*;
(
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [11:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  // Bus idle at time zero.
  initial begin
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
  end

  // One transfer, held until pready is seen high; no latency is assumed.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
                      output logic [31:0] r, output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    r = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : xfer

  // The pending event must be acknowledged before another can be delivered.
  task automatic ack();
    logic [31:0] r;
    logic e;
    xfer(1'b1, ADDR_ACK, 32'h1, r, e);
  endtask : ack
endmodule : dier_host

/* File: tb/dier_chk.sv */
// Checker of the event reporter behaviour at its ports.
`timescale 1ns/1ns
module dier_chk
  import dier_pkg::*;
#(
  parameter int BLINK_HALF = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pslverr,
  input wire logic load_supply_ok,
  input wire logic cnt_step,
  input wire logic cnt_dir_down,
  input wire logic ab_seq_error,
  input wire logic hw_irq,
  input wire logic diag_alarm,
  input wire logic fault_indicator,
  input wire logic direction_status_bit
);
  localparam int BLINK_WIN = 2 * BLINK_HALF + 1;
  logic ack_w;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);

  // Acknowledge write seen in an access cycle.
  assign ack_w = psel && penable && pwrite && paddr == ADDR_ACK && pwdata[0];
  sequence acked;
    hw_irq && ack_w;
  endsequence
  sequence load_lost;
    load_supply_ok ##1 !load_supply_ok;
  endsequence

  irq_hold_a: assert property (hw_irq && !ack_w |=> hw_irq)
    else $error("pending event lost without acknowledge");
  irq_ack_a: assert property (acked |=> !hw_irq)
    else $error("pending event kept after acknowledge");
  diag_load_a: assert property (load_lost |-> ##[0:2] diag_alarm)
    else $error("no alarm on missing load supply");
  diag_ab_a: assert property ($rose(ab_seq_error) |-> ##[1:2] diag_alarm)
    else $error("no alarm on encoder sequence fault");
  blink_on_a: assert property ($rose(diag_alarm) |-> ##[1:BLINK_WIN] fault_indicator)
    else $error("fault indicator not blinking");
  blink_off_a: assert property (!diag_alarm [*2] |-> !fault_indicator)
    else $error("fault indicator lit without alarm");
  err_on_a: assert property (psel && penable && paddr > ADDR_STATUS |-> pslverr)
    else $error("unmapped access not refused");
  err_off_a: assert property (psel && penable && paddr <= ADDR_STATUS |-> !pslverr)
    else $error("mapped access refused");
  rd_zero_a: assert property (!(psel && penable && !pwrite) |-> prdata == 32'h0)
    else $error("read data outside read access");
  dir_a: assert property (cnt_step |=> direction_status_bit == $past(cnt_dir_down))
    else $error("direction bit does not follow step");
endmodule : dier_chk

bind dier_top dier_chk #(.BLINK_HALF(BLINK_HALF)) dier_chk_i (.pclk(pclk), .presetn(presetn),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pslverr(pslverr), .load_supply_ok(load_supply_ok), .cnt_step(cnt_step),
  .cnt_dir_down(cnt_dir_down), .ab_seq_error(ab_seq_error), .hw_irq(hw_irq),
  .diag_alarm(diag_alarm), .fault_indicator(fault_indicator),
  .direction_status_bit(direction_status_bit));

/* File: tb/dier_top_tb.sv */
// Self-checking bench of the event reporter against a queue model of events.
`timescale 1ns/1ns
module dier_top_tb
  import dier_pkg::*;
;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel, penable, pwrite, pready, pslverr, irq, hw_irq, diag, fault, dirb, err;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] din = 16'h0;
  logic load_ok = 1'b1, pulse = 1'b1, dn = 1'b0, step = 1'b0, ab = 1'b0;
  dier_cnt_evt_s cevt = '0;
  int fail_count = 0, samples_checked = 0, cyc = 0, seed = 74, ch;
  logic [31:0] exp_q[$];

  // Clock of 8 ns and a cycle ceiling far above the expected run.
  always #4 pclk = ~pclk;
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 5000) begin
      fail_count++;
      give_verdict();
    end
  end

  // Short blink half period keeps the blink visible in a short run.
  dier_top #(.BLINK_HALF(4)) dier_top_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .digital_in(din), .load_supply_ok(load_ok),
    .cnt_evt(cevt), .cnt_by_pulse(pulse), .cnt_dir_down(dn), .cnt_step(step),
    .ab_seq_error(ab), .irq(irq), .hw_irq(hw_irq), .diag_alarm(diag),
    .fault_indicator(fault), .direction_status_bit(dirb));
  dier_host dier_host_i (.pclk(pclk), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));

  task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp
  task automatic rdchk(input logic [11:0] a, input logic [31:0] exp);
    dier_host_i.xfer(1'b0, a, 32'h0, rd, err);
    cmp(rd, exp);
  endtask : rdchk
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    dier_host_i.xfer(1'b1, a, d, rd, err);
  endtask : wr
  // Toggles one input; with push set, the model records the edge it expects to be reported.
  task automatic tog(input int c, input bit push);
    @(posedge pclk);
    if (push) exp_q.push_back({INFO_STRUCT_ID, 8'(c), din[c] ? EVT_FALL : EVT_RISE});
    din[c] <= ~din[c];
  endtask : tog
  // Waits a bounded time for the event, checks it against the model, then acknowledges.
  task automatic evchk(input logic [31:0] cm);
    int n;
    n = 0;
    while (hw_irq !== 1'b1 && n < 20) begin
      @(posedge pclk);
      n++;
    end
    rdchk(ADDR_EVENT, exp_q.pop_front());
    if (cm != 0) rdchk(ADDR_CHAN_MAP, cm);
    dier_host_i.ack();
  endtask : evchk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : give_verdict

  // Main sequence of scenarios.
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(ADDR_EDGE_EN, EDGE_EN_RST);
    rdchk(ADDR_CNT_EN, {22'h0, CNT_EN_RST});
    rdchk(ADDR_STATUS, 32'h2);
    rdchk(12'h040, 32'h0);
    cmp({31'h0, err}, 32'h1);
    $display("test reset done");
    wr(ADDR_EDGE_EN, 32'hffff_ffff);
    for (int i = 0; i < 8; i++) begin
      ch = {$random(seed)} % 16;
      tog(ch, 1'b1);
      evchk(32'h1 << ch);
    end
    $display("test edges done");
    tog(0, 1'b1);
    repeat (3) @(posedge pclk);
    tog(1, 1'b0);
    repeat (12) @(posedge pclk);
    rdchk(ADDR_DIAG, {16'h0, DIAG_IRQ_LOST});
    rdchk(ADDR_IRQ_STAT, 32'h3);
    evchk(32'h1);
    wr(ADDR_DIAG, 32'h0);
    wr(ADDR_IRQ_STAT, 32'hf);
    rdchk(ADDR_IRQ_STAT, 32'h0);
    $display("test lost done");
    wr(ADDR_CTRL, 32'h1);
    wr(ADDR_CNT_EN, 32'h3ff);
    for (int n = 0; n < 9; n++) begin
      @(posedge pclk);
      cevt <= dier_cnt_evt_s'(10'(1 << n));
      exp_q.push_back({INFO_STRUCT_ID, CNT_CHAN, 8'(n + 1)});
      @(posedge pclk);
      cevt <= '0;
      evchk(32'h0);
    end
    pulse <= 1'b0;
    cevt <= dier_cnt_evt_s'(10'h010);
    @(posedge pclk);
    cevt <= '0;
    dn <= 1'b1;
    step <= 1'b1;
    @(posedge pclk);
    step <= 1'b0;
    pulse <= 1'b1;
    repeat (4) @(posedge pclk);
    cmp({31'h0, hw_irq}, 32'h0);
    dn <= 1'b0;
    step <= 1'b1;
    exp_q.push_back({INFO_STRUCT_ID, CNT_CHAN, 8'h0a});
    @(posedge pclk);
    step <= 1'b0;
    evchk(32'h0);
    $display("test counter done");
    wr(ADDR_IRQ_MASK, 32'h4);
    load_ok <= 1'b0;
    repeat (12) @(posedge pclk);
    cmp({31'h0, irq}, 32'h1);
    rdchk(ADDR_DIAG, {16'h0, DIAG_LOAD_MISSING});
    wr(ADDR_IRQ_MASK, 32'h0);
    repeat (2) @(posedge pclk);
    cmp({31'h0, irq}, 32'h0);
    load_ok <= 1'b1;
    wr(ADDR_IRQ_STAT, 32'h4);
    wr(ADDR_DIAG, 32'h0);
    ab <= 1'b1;
    repeat (12) @(posedge pclk);
    rdchk(ADDR_DIAG, {16'h0, DIAG_AB_SEQ});
    rdchk(ADDR_IRQ_STAT, 32'h9);
    $display("test diagnostics done");
    give_verdict();
  end
endmodule : dier_top_tb
